//--- design/icmo_top.sv
// icache management operations: invalidate, touch, flash clear, debug read
`timescale 1ns/1ps
// What this block does
// - address is index plus base or zero
// - invalidate hit clears line valid
// - invalidate miss does nothing more
// - invalidate ignores cacheable attribute
// - rc bit leaves condition field undefined
// - virtual address uses data address space
// - hit compares virtual address with tag
// - invalidate faults reported as load access
// - invalidate and touch match as loads
// - invalidate lock fault goes to storage interrupt
// - touch miss cacheable fetches block into cache
// - touch hit or inhibited does nothing
// - touch no-execute page does nothing
// - touch faults suppressed, no operation
// - flash clears all lines, operands ignored
// - flash from user mode is privilege violation
// - read index from address bits 17:26
// - read bits 27:29 pick word for data
// - tag high holds tag, valid, zeros
// - tag low holds space, disable, ident
module icmo_top
    import icmo_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                reset_n,
    input  wire logic                req_valid,
    input  wire icmo_req_t           req,
    input  wire logic                data_addr_space,
    input  wire logic                instr_addr_space,
    input  wire logic                problem_state_bit,
    output logic                     xlate_req,
    output logic [ADDR_W-1:0]        effective_addr,
    output logic                     xlate_space,
    input  wire icmo_xlate_t         xlate_rsp,
    output logic                     fill_req,
    output logic [ADDR_W-1:0]        fill_addr,
    input  wire logic                fill_done,
    input  wire logic [DATA_W-1:0]   fill_word [WORDS_LINE],
    output logic                     busy,
    output logic                     done,
    output logic                     data_storage_int,
    output logic                     data_tlb_miss_int,
    output logic                     lock_fault,
    output logic                     privilege_int,
    output logic                     dac_load_check,
    output logic [ADDR_W-1:0]        dac_addr,
    output logic                     cond_field_write,
    output logic [3:0]               cond_field_value,
    output logic [DATA_W-1:0]        debug_data_reg,
    output logic [DATA_W-1:0]        debug_tag_high_reg,
    output logic [DATA_W-1:0]        debug_tag_low_reg
);
    typedef struct packed {
        icmo_state_t        st;
        icmo_op_t           op;
        logic               pending;
        logic [ADDR_W-1:0]  addr;
        logic               space;
        logic               xlate_req;
        logic               fill_req;
        logic               busy;
        logic               done;
        logic               dsi;
        logic               dtlb;
        logic               lock;
        logic               priv;
        logic               dac;
        logic               cond_write;
        logic               idd;
        logic [IDENT_W-1:0] ident;
        logic [DATA_W-1:0]  ddr;
        logic [DATA_W-1:0]  dth;
        logic [DATA_W-1:0]  dtl;
    } icmo_state_s_t;

    icmo_state_s_t s_reg;
    icmo_state_s_t s_next;

    // tag and data arrays; valid bits kept apart so flash clear is one cycle
    icmo_tag_t          tag_mem  [LINES];
    logic [DATA_W-1:0]  data_mem [LINES][WORDS_LINE];
    logic [LINES-1:0]   valid_reg;

    logic [ADDR_W-1:0]     addr_calc;
    logic [IDX_W-1:0]      req_idx;
    logic [WORD_SEL_W-1:0] req_word;
    icmo_tag_t             req_tag;
    logic [IDX_W-1:0]      cur_idx;
    icmo_tag_t             cur_tag;
    logic                  hit;
    logic                  no_exec;
    logic                  clear_line;
    logic                  flash_all;
    logic                  write_line;

    // base of zero when the field selects register zero
    assign addr_calc = (req.base_is_zero ? ZERO_WORD : req.base_operand_reg)
                     + req.index_operand_reg;
    assign req_idx  = addr_calc[IDX_LSB +: IDX_W];
    assign req_word = addr_calc[WSEL_LSB +: WORD_SEL_W];
    assign req_tag  = tag_mem[req_idx];
    assign cur_idx  = s_reg.addr[IDX_LSB +: IDX_W];
    assign cur_tag  = tag_mem[cur_idx];
    // virtual tag compare: address and space must agree, ident too unless either id disable bit is set
    assign hit = valid_reg[cur_idx]
              && cur_tag.tag_effective_addr
                 == s_reg.addr[TAG_ADDR_LSB +: TAG_ADDR_W]
              && cur_tag.translation_space == s_reg.space
              && (xlate_rsp.id_disable_bit || cur_tag.id_disable_bit
                  || cur_tag.translation_ident
                     == xlate_rsp.translation_ident);
    assign no_exec = problem_state_bit ? xlate_rsp.no_exec_user
                                       : xlate_rsp.no_exec_super;

    always_comb
    begin
        s_next           = s_reg;
        s_next.done      = 1'b0;
        s_next.dsi       = 1'b0;
        s_next.dtlb      = 1'b0;
        s_next.lock      = 1'b0;
        s_next.priv      = 1'b0;
        s_next.dac       = 1'b0;
        s_next.cond_write = 1'b0;
        s_next.xlate_req = 1'b0;
        clear_line       = 1'b0;
        flash_all        = 1'b0;
        write_line       = 1'b0;
        unique case (s_reg.st)
            ICMO_ST_IDLE:
            begin
                if (s_reg.pending && xlate_rsp.valid)
                begin
                    s_next.pending = 1'b0;
                    unique case (s_reg.op)
                        ICMO_OP_INVAL:
                        begin
                            // treated as a load for fault checks
                            s_next.dsi  = xlate_rsp.storage_fault
                                       || xlate_rsp.lock_fault;
                            s_next.lock = xlate_rsp.lock_fault;
                            s_next.dtlb = xlate_rsp.tlb_miss;
                            // cacheable attribute is not looked at
                            clear_line = hit && !xlate_rsp.tlb_miss
                                      && !xlate_rsp.storage_fault
                                      && !xlate_rsp.lock_fault;
                            s_next.busy = 1'b0;
                            s_next.done = 1'b1;
                        end
                        ICMO_OP_TOUCH:
                        begin
                            // keep the page ident: the answer is gone
                            // by the time the fill returns
                            s_next.idd   = xlate_rsp.id_disable_bit;
                            s_next.ident = xlate_rsp.translation_ident;
                            // faults are swallowed, touch is only a hint
                            if (!xlate_rsp.tlb_miss
                                && !xlate_rsp.storage_fault
                                && !xlate_rsp.lock_fault
                                && !hit && xlate_rsp.cacheable
                                && !no_exec)
                            begin
                                s_next.st       = ICMO_ST_FILL;
                                s_next.fill_req = 1'b1;
                            end
                            else
                            begin
                                s_next.busy = 1'b0;
                                s_next.done = 1'b1;
                            end
                        end
                        default:
                        begin
                            s_next.busy = 1'b0;
                            s_next.done = 1'b1;
                        end
                    endcase
                end
                else if (req_valid && !s_reg.busy && !s_reg.pending)
                begin
                    s_next.op    = req.op;
                    s_next.addr  = addr_calc;
                    s_next.space = data_addr_space;
                    // condition field left undefined: never written
                    s_next.cond_write = 1'b0;
                    unique case (req.op)
                        ICMO_OP_INVAL, ICMO_OP_TOUCH:
                        begin
                            s_next.busy      = 1'b1;
                            s_next.pending   = 1'b1;
                            s_next.xlate_req = 1'b1;
                            s_next.dac       = 1'b1;
                        end
                        ICMO_OP_FLASH:
                        begin
                            // operands unused; only privilege gates it
                            flash_all   = !problem_state_bit;
                            s_next.priv = problem_state_bit;
                            s_next.done = 1'b1;
                        end
                        ICMO_OP_READ:
                        begin
                            // privileged like flash clear
                            s_next.priv = problem_state_bit;
                            s_next.done = 1'b1;
                            if (!problem_state_bit)
                            begin
                                s_next.ddr =
                                    data_mem[req_idx][req_word];
                                s_next.dth = {
                                    req_tag.tag_effective_addr,
                                    valid_reg[req_idx],
                                    7'h00};
                                s_next.dtl = {22'h0,
                                    req_tag.translation_space,
                                    req_tag.id_disable_bit,
                                    req_tag.translation_ident};
                            end
                        end
                        default:
                        begin
                            s_next.busy = 1'b0;
                        end
                    endcase
                end
            end
            ICMO_ST_FILL:
            begin
                s_next.fill_req = 1'b0;
                if (fill_done)
                begin
                    write_line  = 1'b1;
                    s_next.st   = ICMO_ST_IDLE;
                    s_next.busy = 1'b0;
                    s_next.done = 1'b1;
                end
            end
            default:
            begin
                s_next.st = ICMO_ST_IDLE;
            end
        endcase
    end

    // line read samples the arrays at acceptance, so results stand at done
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // valid bits need reset; data and tag arrays do not
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            valid_reg <= '0;
        end
        else if (flash_all)
        begin
            valid_reg <= '0;
        end
        else if (clear_line)
        begin
            valid_reg[cur_idx] <= 1'b0;
        end
        else if (write_line)
        begin
            valid_reg[cur_idx] <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (write_line)
        begin
            tag_mem[cur_idx].valid              <= 1'b1;
            tag_mem[cur_idx].tag_effective_addr
                <= s_reg.addr[TAG_ADDR_LSB +: TAG_ADDR_W];
            tag_mem[cur_idx].translation_space  <= s_reg.space;
            tag_mem[cur_idx].id_disable_bit     <= s_reg.idd;
            tag_mem[cur_idx].translation_ident  <= s_reg.ident;
            data_mem[cur_idx] <= fill_word;
        end
    end

    assign xlate_req          = s_reg.xlate_req;
    assign effective_addr     = s_reg.addr;
    assign xlate_space        = s_reg.space;
    assign fill_req           = s_reg.fill_req;
    assign fill_addr          = {s_reg.addr[ADDR_W-1:IDX_LSB], 5'h00};
    assign busy               = s_reg.busy;
    assign done               = s_reg.done;
    assign data_storage_int   = s_reg.dsi;
    assign data_tlb_miss_int  = s_reg.dtlb;
    assign lock_fault         = s_reg.lock;
    assign privilege_int      = s_reg.priv;
    assign dac_load_check     = s_reg.dac;
    assign dac_addr           = s_reg.addr;
    assign cond_field_write   = s_reg.cond_write;
    assign cond_field_value   = 4'h0;
    assign debug_data_reg     = s_reg.ddr;
    assign debug_tag_high_reg = s_reg.dth;
    assign debug_tag_low_reg  = s_reg.dtl;
endmodule : icmo_top

//--- include/icmo_pkg.sv
// package: constants and carriers for the icache management block
package icmo_pkg;
    localparam int ADDR_W      = 32;
    localparam int DATA_W      = 32;
    localparam int IDX_W       = 10;
    localparam int WORD_SEL_W  = 3;
    localparam int WORDS_LINE  = 8;
    localparam int LINES       = 1024;
    localparam int TAG_ADDR_W  = 24;
    localparam int IDENT_W     = 8;
    // msb-first bit n maps to lsb-order bit 31-n
    localparam int IDX_LSB     = 5;
    localparam int WSEL_LSB    = 2;
    localparam int TAG_ADDR_LSB = 8;
    localparam int TH_VALID    = 7;
    localparam int TL_SPACE    = 9;
    localparam int TL_IDDIS    = 8;
    localparam int TL_IDENT_LSB = 0;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;

    typedef enum logic [2:0] {
        ICMO_OP_NONE  = 3'h0,
        ICMO_OP_INVAL = 3'h1,
        ICMO_OP_TOUCH = 3'h2,
        ICMO_OP_FLASH = 3'h3,
        ICMO_OP_READ  = 3'h4
    } icmo_op_t;

    typedef enum logic [1:0] {
        ICMO_ST_IDLE  = 2'h0,
        ICMO_ST_FILL  = 2'h1
    } icmo_state_t;

    typedef struct packed {
        icmo_op_t          op;
        logic              base_is_zero;
        logic [ADDR_W-1:0] base_operand_reg;
        logic [ADDR_W-1:0] index_operand_reg;
        logic              rc_bit;
    } icmo_req_t;

    // translation answer for the address just issued
    typedef struct packed {
        logic              valid;
        logic              tlb_miss;
        logic              storage_fault;
        logic              lock_fault;
        logic              cacheable;
        logic              no_exec_user;
        logic              no_exec_super;
        logic              id_disable_bit;
        logic [IDENT_W-1:0] translation_ident;
    } icmo_xlate_t;

    typedef struct packed {
        logic              valid;
        logic [TAG_ADDR_W-1:0] tag_effective_addr;
        logic              translation_space;
        logic              id_disable_bit;
        logic [IDENT_W-1:0] translation_ident;
    } icmo_tag_t;
endpackage : icmo_pkg

//--- sim/icmo_far_model.sv
// far side model: translation answers and line fills
`timescale 1ns/1ps
module icmo_far_model
    import icmo_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              xlate_req,
    input  wire logic              fill_req,
    input  wire logic [ADDR_W-1:0] fill_addr,
    input  wire icmo_xlate_t       cfg,
    input  wire logic [3:0]        delay,
    output icmo_xlate_t            xlate_rsp,
    output logic                   fill_done,
    output logic [DATA_W-1:0]      fill_word [WORDS_LINE]
);
    logic [4:0]        xcnt_reg;
    logic [4:0]        fcnt_reg;
    logic [ADDR_W-1:0] line_reg;
    logic              flip_reg;
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            xcnt_reg <= 5'h00;
            fcnt_reg <= 5'h00;
            flip_reg <= 1'b0;
        end
        else
        begin
            flip_reg <= !flip_reg;
            xcnt_reg <= xlate_req ? delay + 5'h01
                      : xcnt_reg - {4'h0, xcnt_reg != 5'h00};
            fcnt_reg <= fill_req ? delay + 5'h02
                      : fcnt_reg - {4'h0, fcnt_reg != 5'h00};
            if (fill_req)
                line_reg <= fill_addr;
        end
    end
    // idle answers flip each cycle so stale fields are never trusted
    assign xlate_rsp = (xcnt_reg == 5'h01) ? {1'b1, cfg[14:0]}
                     : {1'b0, cfg[14:0] ^ {15{flip_reg}}};
    assign fill_done = (fcnt_reg == 5'h01);
    always_comb
        for (int i = 0; i < WORDS_LINE; i++)
            fill_word[i] = fill_done ? line_reg + 32'(4 * i) : {32{flip_reg}};
endmodule : icmo_far_model

//--- sim/icmo_monitor.sv
// checker for icache management port timing
`timescale 1ns/1ps
module icmo_monitor
    import icmo_pkg::*;
(
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              req_valid,
    input wire icmo_req_t         req,
    input wire logic              data_addr_space,
    input wire logic              problem_state_bit,
    input wire logic              busy,
    input wire logic              done,
    input wire logic              xlate_req,
    input wire logic [ADDR_W-1:0] effective_addr,
    input wire logic              xlate_space,
    input wire icmo_xlate_t       xlate_rsp,
    input wire logic              fill_req,
    input wire logic [ADDR_W-1:0] fill_addr,
    input wire logic              data_storage_int,
    input wire logic              data_tlb_miss_int,
    input wire logic              lock_fault,
    input wire logic              privilege_int,
    input wire logic              dac_load_check,
    input wire logic [DATA_W-1:0] debug_tag_high_reg,
    input wire logic [DATA_W-1:0] debug_tag_low_reg,
    input wire logic [ADDR_W-1:0] dac_addr,
    input wire logic              cond_field_write,
    input wire logic [3:0]        cond_field_value
);
    wire      take = req_valid && !busy;
    icmo_op_t last_op_reg;
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
            last_op_reg <= ICMO_OP_NONE;
        else if (take)
            last_op_reg <= req.op;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_take_mem;
        take && (req.op == ICMO_OP_INVAL || req.op == ICMO_OP_TOUCH);
    endsequence
    sequence s_inval_ans;
        xlate_rsp.valid && busy && last_op_reg == ICMO_OP_INVAL;
    endsequence
    AST_EA_FORM: assert property (s_take_mem |=> effective_addr ==
        ($past(req.base_is_zero) ? 32'h00000000 : $past(req.base_operand_reg))
        + $past(req.index_operand_reg)) else $error("bad address");
    AST_XLATE_SPACE: assert property (s_take_mem |=> xlate_req
        && busy && dac_load_check && dac_addr == effective_addr
        && xlate_space == $past(data_addr_space))
        else $error("bad translation request");
    AST_INV_TLB: assert property (s_inval_ans ##0 xlate_rsp.tlb_miss
        |=> done && data_tlb_miss_int) else $error("tlb miss lost");
    AST_INV_LOCK: assert property (s_inval_ans ##0 xlate_rsp.lock_fault
        |=> lock_fault && data_storage_int) else $error("lock fault lost");
    AST_TOUCH_QUIET: assert property (done && last_op_reg == ICMO_OP_TOUCH
        |-> !(data_storage_int || data_tlb_miss_int || lock_fault))
        else $error("touch raised fault");
    AST_FILL_LINE: assert property (fill_req
        |-> fill_addr == {effective_addr[31:5], 5'h00} && busy
        && last_op_reg == ICMO_OP_TOUCH && $past(xlate_rsp.valid)
        && $past(xlate_rsp.cacheable)) else $error("bad fill");
    AST_FLASH_PRIV: assert property (take && req.op == ICMO_OP_FLASH
        && problem_state_bit |=> privilege_int) else $error("no privilege");
    AST_TAG_ZERO: assert property (debug_tag_high_reg[6:0] == 7'h00
        && debug_tag_low_reg[31:10] == 22'h000000) else $error("reserved set");
    AST_COND_QUIET: assert property (!cond_field_write
        && cond_field_value == 4'h0) else $error("condition field written");
endmodule : icmo_monitor

//--- sim/icmo_top_tb.sv
// testbench: random and corner icache management operations
`timescale 1ns/1ps
module icmo_top_tb
    import icmo_pkg::*;
;
    localparam logic [6:0] CACHE = 7'h08;
    localparam logic [6:0] TLB   = 7'h48;
    localparam logic [6:0] SF    = 7'h28;
    localparam logic [6:0] LOCK  = 7'h18;
    logic              clk, reset_n, req_valid, problem_state_bit;
    logic              data_addr_space, instr_addr_space, xlate_req;
    logic              xlate_space, fill_req, fill_done, busy, done;
    logic              data_storage_int, data_tlb_miss_int, lock_fault;
    logic              privilege_int, dac_load_check;
    logic [ADDR_W-1:0] effective_addr, fill_addr, dac_addr, a, r;
    logic [DATA_W-1:0] debug_data_reg, debug_tag_high_reg, debug_tag_low_reg;
    logic [DATA_W-1:0] fill_word [WORDS_LINE];
    icmo_req_t         req;
    icmo_xlate_t       xlate_rsp, cfg;
    logic [3:0]        delay;
    logic [4:0]        saw;
    logic [6:0]        quiet [4] = '{TLB, SF, 7'h00, 7'h0C};
    logic [6:0]        bad [3] = '{TLB, SF, LOCK};
    logic [4:0]        bad_saw [3] = '{5'h04, 5'h08, 5'h0A};
    logic [31:0]       seed;
    int                fails, compares;
    icmo_top i_icmo_top (.clk, .reset_n, .req_valid, .req, .data_addr_space,
        .instr_addr_space, .problem_state_bit, .xlate_req, .effective_addr,
        .xlate_space, .xlate_rsp, .fill_req, .fill_addr, .fill_done,
        .fill_word, .busy, .done, .data_storage_int, .data_tlb_miss_int,
        .lock_fault, .privilege_int, .dac_load_check, .dac_addr,
        .cond_field_write(), .cond_field_value(), .debug_data_reg,
        .debug_tag_high_reg,
        .debug_tag_low_reg);
    icmo_far_model i_icmo_far_model (.clk, .reset_n, .xlate_req, .fill_req,
        .fill_addr, .cfg, .delay, .xlate_rsp, .fill_done, .fill_word);
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict
    function automatic logic [31:0] exp_th(logic [31:0] addr);
        return {addr[31:8], 1'b1, 7'h00};
    endfunction : exp_th
    function automatic logic [31:0] exp_tl(logic s, logic d, logic [7:0] t);
        return {22'h000000, s, d, t};
    endfunction : exp_tl
    // request and attributes change together at one edge, then wait done, or 40 cycles if done is not needed
    task automatic run_op(input icmo_op_t op, input logic [6:0] f,
                          input logic ps, input logic need);
        int          n;
        logic [31:0] b;
        b = $random(seed);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{op, b[1], b, b[1] ? a : a - b, b[0]};
        cfg <= {1'b0, f, r[15:8]};
        data_addr_space <= r[0];
        instr_addr_space <= !r[0];
        delay <= r[4:1];
        problem_state_bit <= ps;
        @(posedge clk);
        req_valid <= 1'b0;
        saw = 5'h00;
        for (n = 0; n < 40; n++)
        begin
            #1;
            saw = saw | {fill_req, data_storage_int, data_tlb_miss_int,
                         lock_fault, privilege_int};
            if (need && done === 1'b1)
                break;
            @(posedge clk);
        end
        if (need && n == 40)
        begin
            fails++;
            give_verdict();
        end
    endtask : run_op
    task automatic rd(input logic v);
        run_op(ICMO_OP_READ, CACHE, 1'b0, 1'b1);
        if (v)
        begin
            chk(debug_tag_high_reg, exp_th(a));
            chk(debug_data_reg, {a[31:2], 2'h0});
        end
        else
            chk({31'h0, debug_tag_high_reg[TH_VALID]}, 32'h0);
    endtask : rd
    initial
    begin
        seed = 32'h6ea9;
        fails = 0;
        compares = 0;
        reset_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        data_addr_space = 1'b0;
        instr_addr_space = 1'b0;
        problem_state_bit = 1'b0;
        cfg = '0;
        delay = 4'h0;
        a = 32'h00000000;
        r = 32'h00000000;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        rd(1'b0);
        $display("test reset_state done");
        repeat (4)
        begin
            a = $random(seed);
            r = $random(seed);
            run_op(ICMO_OP_TOUCH, CACHE | {6'h00, r[5]}, 1'b0, 1'b1);
            chk({31'h0, saw[4]}, 32'h1);
            chk(effective_addr, a);
            chk(dac_addr, a);
            rd(1'b1);
            chk(debug_tag_low_reg, exp_tl(r[0], r[5], r[15:8]));
            run_op(ICMO_OP_TOUCH, CACHE, 1'b0, 1'b1);
            chk({27'h0, saw}, 32'h0);
        end
        $display("test touch_read done");
        run_op(ICMO_OP_INVAL, 7'h00, 1'b0, 1'b1);
        rd(1'b0);
        run_op(ICMO_OP_INVAL, CACHE, 1'b0, 1'b1);
        chk({27'h0, saw}, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            run_op(ICMO_OP_TOUCH, quiet[i], i == 3, 1'b1);
            chk({27'h0, saw}, 32'h0);
        end
        for (int i = 0; i < 3; i++)
        begin
            run_op(ICMO_OP_INVAL, bad[i], 1'b0, 1'b1);
            chk({27'h0, saw}, {27'h0, bad_saw[i]});
        end
        $display("test faults done");
        run_op(ICMO_OP_TOUCH, CACHE, 1'b0, 1'b1);
        run_op(ICMO_OP_FLASH, CACHE, 1'b1, 1'b0);
        chk({27'h0, saw}, 32'h1);
        rd(1'b1);
        run_op(ICMO_OP_FLASH, CACHE, 1'b0, 1'b1);
        rd(1'b0);
        $display("test flash done");
        give_verdict();
    end
endmodule : icmo_top_tb
bind icmo_top icmo_monitor i_icmo_monitor (.clk, .reset_n, .req_valid, .req,
    .data_addr_space, .problem_state_bit, .busy, .done, .xlate_req,
    .effective_addr, .xlate_space, .xlate_rsp, .fill_req, .fill_addr,
    .data_storage_int, .data_tlb_miss_int, .lock_fault, .privilege_int,
    .dac_load_check, .debug_tag_high_reg, .debug_tag_low_reg, .dac_addr,
    .cond_field_write, .cond_field_value);
